/* hw/fps_pkg.sv */
// Package: register map, field layout and timing constants of the function power status block
package fps_pkg;

    // Bus geometry
    localparam int unsigned APB_AW = 16;
    localparam int unsigned APB_DW = 32;

    // Register byte addresses
    localparam logic [15:0] FUNC_ACT_PWR_ADDR = 16'h5b30;
    localparam logic [15:0] IRQ_STATUS_ADDR   = 16'h5b40;
    localparam logic [15:0] IRQ_CLEAR_ADDR    = 16'h5b44;
    localparam logic [15:0] IRQ_ENABLE_ADDR   = 16'h5b48;

    // Field positions of the function status word
    localparam int unsigned CHG_FLAG_BIT  = 31;
    localparam int unsigned KBD_EN_BIT    = 26;
    localparam int unsigned F4_LVL_LSB    = 24;
    localparam int unsigned F3_AUX_BIT    = 21;
    localparam int unsigned SER_EN_BIT    = 20;
    localparam int unsigned F3_LVL_LSB    = 18;
    localparam int unsigned F2_AUX_BIT    = 15;
    localparam int unsigned DISK_EN_BIT   = 14;
    localparam int unsigned F2_LVL_LSB    = 12;
    localparam logic [31:0] RSVD_MASK     = 32'h00c3_0c00;

    // Interrupt status layout
    localparam int unsigned IRQ_CHG_BIT   = 0;
    localparam logic [31:0] IRQ_MASK      = 32'h0000_0001;

    // Non-volatile word addresses and bit positions inside the loaded word
    localparam logic [7:0] NVM_WORD_DUAL   = 8'h21;
    localparam logic [7:0] NVM_WORD_SINGLE = 8'h49;
    localparam int unsigned NVM_KBD_BIT    = 0;
    localparam int unsigned NVM_SER_BIT    = 1;
    localparam int unsigned NVM_DISK_BIT   = 2;

    // Power level encoding
    localparam logic [1:0] PWR_RESET      = 2'h0;
    localparam logic [1:0] PWR_ACTIVE_UNI = 2'h1;
    localparam logic [1:0] PWR_ACTIVE_INI = 2'h2;
    localparam logic [1:0] PWR_LOW        = 2'h3;

    // Quiet time after a read clear, in cycles of the controller clock
    localparam int unsigned   CHG_HOLD_CYC = 8;
    localparam logic [3:0]    CHG_HOLD_CNT = 4'(CHG_HOLD_CYC);

    // Per-function state as seen from the host configuration space
    typedef struct packed {
        logic       aux_pm_shadow;
        logic [1:0] power_level;
    } fps_func_stat_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [15:0] data;
    } fps_nvm_word_t;

endpackage : fps_pkg

/* hw/fps_level_watch.sv */
// Captures per-function status and flags any power level change
module fps_level_watch (
    input  wire logic                    sys_clk_i,
    input  wire logic                    reset_n_i,
    input  wire fps_pkg::fps_func_stat_t func2_i,
    input  wire fps_pkg::fps_func_stat_t func3_i,
    input  wire fps_pkg::fps_func_stat_t func4_i,
    output logic [1:0]                   func2_level_o,
    output logic [1:0]                   func3_level_o,
    output logic [1:0]                   func4_level_o,
    output logic                         func2_aux_o,
    output logic                         func3_aux_o,
    output logic                         change_o
);
    import fps_pkg::*;

    logic [1:0] f2_reg;
    logic [1:0] f3_reg;
    logic [1:0] f4_reg;
    logic       a2_reg;
    logic       a3_reg;
    logic       chg_reg;
    wire  logic chg_next;

    assign chg_next = (func2_i.power_level != f2_reg) | (func3_i.power_level != f3_reg) |
                      (func4_i.power_level != f4_reg);

    // Fields start in the reset power state
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            f2_reg  <= PWR_RESET;                               // R9
            f3_reg  <= PWR_RESET;
            f4_reg  <= PWR_RESET;
            a2_reg  <= 1'b0;
            a3_reg  <= 1'b0;
            chg_reg <= 1'b0;
        end else begin
            f2_reg  <= func2_i.power_level;                     // R8
            f3_reg  <= func3_i.power_level;                     // R5
            f4_reg  <= func4_i.power_level;                     // R2
            a2_reg  <= func2_i.aux_pm_shadow;                   // R6
            a3_reg  <= func3_i.aux_pm_shadow;                   // R3
            chg_reg <= chg_next;                                // R10
        end
    end

    assign func2_level_o = f2_reg;
    assign func3_level_o = f3_reg;
    assign func4_level_o = f4_reg;
    assign func2_aux_o   = a2_reg;
    assign func3_aux_o   = a3_reg;
    assign change_o      = chg_reg;

endmodule : fps_level_watch

/* hw/fps_top.sv */
// Function power status register bank with APB slave and interrupt logic
//
// Overview of operation
// [R1] Keyboard interface enable loaded from word 49h
// [R2] Function 4 power level in bits 25:24
// [R3] Bit 21 mirrors function 3 aux shadow
// [R4] Serial redirect enable from 21h or 49h
// [R5] Function 3 power level in bits 19:18
// [R6] Bit 15 mirrors function 2 aux shadow
// [R7] Disk redirect enable from 21h or 49h
// [R8] Function 2 power level in bits 13:12
// [R9] Levels: reset, active uninit, active init, low
// [R10] Change flag, read clears, eight quiet cycles
// [R11] Reserved bits read zero, writes ignored
module fps_top (
    input  wire logic                    sys_clk_i,
    input  wire logic                    reset_n_i,
    input  wire logic                    psel_i,
    input  wire logic                    penable_i,
    input  wire logic                    pwrite_i,
    input  wire logic [15:0]             paddr_i,
    input  wire logic [31:0]             pwdata_i,
    input  wire logic [3:0]              pstrb_i,
    output logic                         pready_o,
    output logic [31:0]                  prdata_o,
    output logic                         pslverr_o,
    input  wire fps_pkg::fps_func_stat_t func2_i,
    input  wire fps_pkg::fps_func_stat_t func3_i,
    input  wire fps_pkg::fps_func_stat_t func4_i,
    input  wire fps_pkg::fps_nvm_word_t  nvm_word_i,
    input  wire logic                    single_port_strap_i,
    output logic                         mng_change_o,
    output logic                         irq_o
);
    import fps_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic [1:0] f2_lvl;
    logic [1:0] f3_lvl;
    logic [1:0] f4_lvl;
    logic       f2_aux;
    logic       f3_aux;
    logic       lvl_change;

    logic        strap_s1_reg;
    logic        strap_s2_reg;
    logic        single_reg;
    logic        strap_done_reg;
    logic        kbd_en_reg;
    logic        ser_en_reg;
    logic        disk_en_reg;
    logic        flag_reg;
    logic        flag_next;
    logic        pend_reg;
    logic        pend_next;
    logic [3:0]  hold_reg;
    logic [3:0]  hold_next;
    logic [31:0] irq_stat_reg;
    logic [31:0] irq_en_reg;
    logic        irq_reg;
    logic        pready_reg;
    logic [31:0] prdata_reg;
    logic        pslverr_reg;

    wire logic        access;
    wire logic        capture;
    wire logic        is_wr;
    wire logic        is_rd;
    wire logic        hit_fps;
    wire logic        hit_stat;
    wire logic        hit_clr;
    wire logic        hit_en;
    wire logic        mapped;
    wire logic        rd_clear;
    wire logic        nvm_dual_hit;
    wire logic        nvm_single_hit;
    wire logic [31:0] fps_word;
    wire logic [31:0] rd_mux;
    wire logic [31:0] wr_mask;
    wire logic [31:0] clr_bits;
    wire logic [31:0] irq_stat_next;

    ////////////////////////////////////////////////////////////////////////////////
    // Function status capture

    fps_level_watch fps_level_watch_inst (
        .sys_clk_i     (sys_clk_i),
        .reset_n_i     (reset_n_i),
        .func2_i       (func2_i),
        .func3_i       (func3_i),
        .func4_i       (func4_i),
        .func2_level_o (f2_lvl),
        .func3_level_o (f3_lvl),
        .func4_level_o (f4_lvl),
        .func2_aux_o   (f2_aux),
        .func3_aux_o   (f3_aux),
        .change_o      (lvl_change)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Variant strap, synchronised, then followed after reset release until it reads single port, which holds until reset

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_s1_reg   <= 1'b0;
            strap_s2_reg   <= 1'b0;
            single_reg     <= 1'b0;
            strap_done_reg <= 1'b0;
        end else begin
            strap_s1_reg   <= single_port_strap_i;
            strap_s2_reg   <= strap_s1_reg;
            strap_done_reg <= 1'b1;
            if (strap_done_reg && !single_reg && (strap_s2_reg != single_reg)) begin
                single_reg <= strap_s2_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Enable bits loaded from non-volatile words

    assign nvm_dual_hit   = nvm_word_i.valid && !single_reg && (nvm_word_i.addr == NVM_WORD_DUAL);
    assign nvm_single_hit = nvm_word_i.valid && single_reg && (nvm_word_i.addr == NVM_WORD_SINGLE);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            kbd_en_reg  <= 1'b0;
            ser_en_reg  <= 1'b0;
            disk_en_reg <= 1'b0;
        end else if (nvm_single_hit) begin
            kbd_en_reg  <= nvm_word_i.data[NVM_KBD_BIT];        // R1
            ser_en_reg  <= nvm_word_i.data[NVM_SER_BIT];        // R4
            disk_en_reg <= nvm_word_i.data[NVM_DISK_BIT];       // R7
        end else if (nvm_dual_hit) begin
            ser_en_reg  <= nvm_word_i.data[NVM_SER_BIT];        // R4
            disk_en_reg <= nvm_word_i.data[NVM_DISK_BIT];       // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status word; reserved ranges are tied low

    assign fps_word = {flag_reg, 4'h0, kbd_en_reg, f4_lvl, 2'h0, f3_aux, ser_en_reg,
                       f3_lvl, 2'h0, f2_aux, disk_en_reg, f2_lvl, 12'h000} & ~RSVD_MASK; // R11

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode: one wait state, answer registered

    assign access   = psel_i && penable_i;
    assign capture  = access && !pready_reg;
    assign is_wr    = capture && pwrite_i;
    assign is_rd    = capture && !pwrite_i;
    assign hit_fps  = (paddr_i == FUNC_ACT_PWR_ADDR);
    assign hit_stat = (paddr_i == IRQ_STATUS_ADDR);
    assign hit_clr  = (paddr_i == IRQ_CLEAR_ADDR);
    assign hit_en   = (paddr_i == IRQ_ENABLE_ADDR);
    assign mapped   = hit_fps || hit_stat || hit_clr || hit_en;
    assign rd_clear = is_rd && hit_fps;
    assign wr_mask  = {{8{pstrb_i[3]}}, {8{pstrb_i[2]}}, {8{pstrb_i[1]}}, {8{pstrb_i[0]}}};

    assign rd_mux = hit_fps  ? fps_word :
                    hit_stat ? irq_stat_reg :
                    hit_en   ? irq_en_reg : 32'h0000_0000;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= capture;
            pslverr_reg <= capture && !mapped;
            prdata_reg  <= is_rd ? rd_mux : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Change flag: a read clears it, and an event seen during the quiet time is kept
    // pending so that it is delayed rather than lost

    always_comb begin
        flag_next = flag_reg;
        pend_next = pend_reg;
        hold_next = hold_reg;
        if (rd_clear) begin
            flag_next = 1'b0;                                   // R10
            hold_next = CHG_HOLD_CNT;
            pend_next = pend_reg || lvl_change;
        end else if (hold_reg != 4'h0) begin
            hold_next = hold_reg - 4'h1;
            pend_next = pend_reg || lvl_change;
        end else if (lvl_change || pend_reg) begin
            flag_next = 1'b1;                                   // R10
            pend_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flag_reg <= 1'b0;
            pend_reg <= 1'b0;
            hold_reg <= 4'h0;
        end else begin
            flag_reg <= flag_next;
            pend_reg <= pend_next;
            hold_reg <= hold_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status, clear and enable; a new event wins over a clear

    assign clr_bits      = (is_wr && hit_clr) ? (pwdata_i & wr_mask & IRQ_MASK) : 32'h0000_0000;
    assign irq_stat_next = ((irq_stat_reg & ~clr_bits) |
                            {31'h0000_0000, lvl_change}) & IRQ_MASK;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_stat_reg <= 32'h0000_0000;
            irq_en_reg   <= 32'h0000_0000;
            irq_reg      <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            if (is_wr && hit_en) begin
                irq_en_reg <= ((pwdata_i & wr_mask) | (irq_en_reg & ~wr_mask)) & IRQ_MASK;
            end
            irq_reg <= |(irq_stat_next & irq_en_reg);
        end
    end

    assign pready_o     = pready_reg;
    assign prdata_o     = prdata_reg;
    assign pslverr_o    = pslverr_reg;
    assign mng_change_o = flag_reg;
    assign irq_o        = irq_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);

    kbd_nvm_load_a: assert property (nvm_single_hit |=> // R1
                                     kbd_en_reg == $past(nvm_word_i.data[NVM_KBD_BIT]))
        else $error("keyboard enable not loaded from single-port word");

    // Fields lag their inputs by one edge; the first edge after reset still shows the reset level
    f4_level_a: assert property ($past(reset_n_i) |-> // R2
                                 fps_word[F4_LVL_LSB +: 2] == $past(func4_i.power_level))
        else $error("function 4 level does not follow input");

    f3_aux_mirror_a: assert property ($past(reset_n_i) |-> // R3
                                      fps_word[F3_AUX_BIT] == $past(func3_i.aux_pm_shadow))
        else $error("function 3 aux shadow does not follow input");

    ser_dual_load_a: assert property (nvm_dual_hit |=> // R4
                                      ser_en_reg == $past(nvm_word_i.data[NVM_SER_BIT]))
        else $error("serial enable not loaded from dual-port word");

    f3_level_a: assert property ($past(reset_n_i) |-> // R5
                                 fps_word[F3_LVL_LSB +: 2] == $past(func3_i.power_level))
        else $error("function 3 level does not follow input");

    f2_aux_mirror_a: assert property ($past(reset_n_i) |-> // R6
                                      fps_word[F2_AUX_BIT] == $past(func2_i.aux_pm_shadow))
        else $error("function 2 aux shadow does not follow input");

    disk_load_a: assert property ((nvm_dual_hit || nvm_single_hit) |=> // R7
                                  disk_en_reg == $past(nvm_word_i.data[NVM_DISK_BIT]))
        else $error("disk enable not loaded");

    f2_level_a: assert property ($past(reset_n_i) |-> // R8
                                 fps_word[F2_LVL_LSB +: 2] == $past(func2_i.power_level))
        else $error("function 2 level does not follow input");

    reset_level_a: assert property (!$past(reset_n_i) |-> // R9
                                    (fps_word[F2_LVL_LSB +: 2] == PWR_RESET) &&
                                    (fps_word[F3_LVL_LSB +: 2] == PWR_RESET) &&
                                    (fps_word[F4_LVL_LSB +: 2] == PWR_RESET))
        else $error("power levels not in reset state after reset");

    chg_quiet_a: assert property (rd_clear |=> !flag_reg [*8]) // R10
        else $error("change flag set within quiet time");

    chg_raise_a: assert property ((lvl_change && hold_reg == 4'h0 && !rd_clear) |=> // R10
                                  flag_reg)
        else $error("change flag not raised on level change");

    chg_kept_a: assert property ((rd_clear && lvl_change) |-> ##[9:10] flag_reg) // R10
        else $error("change during read clear was lost");

    quiet_load_a: assert property (rd_clear |=> (hold_reg == CHG_HOLD_CNT) && !flag_reg) // R10
        else $error("quiet time not started by read clear");

    irq_set_wins_a: assert property (lvl_change |=> irq_stat_reg[IRQ_CHG_BIT]) // R10
        else $error("level change did not set interrupt status");

    rsvd_zero_a: assert property (!$past(hit_fps) || // R11
                                  ((prdata_reg & RSVD_MASK) == 32'h0000_0000))
        else $error("reserved status bits read nonzero");

    nvm_ignore_a: assert property ((nvm_word_i.valid && !nvm_dual_hit && // R4 R7
                                    !nvm_single_hit) |=>
                                   $stable({kbd_en_reg, ser_en_reg, disk_en_reg}))
        else $error("enable bits changed by an ignored word");

    irq_level_a: assert property (irq_reg == |(irq_stat_reg & irq_en_reg) ||
                                  $changed(irq_stat_reg) || $changed(irq_en_reg))
        else $error("interrupt output disagrees with status and enable");

    ready_pulse_a: assert property (pready_reg |=> !pready_reg)
        else $error("ready held longer than one cycle");

    unmapped_err_a: assert property ((capture && !mapped) |=>
                                     pslverr_reg && (prdata_reg == 32'h0000_0000))
        else $error("unmapped access not answered with error");

endmodule : fps_top

/* tb/fps_fw_model.sv */
// Firmware-side APB master that reads and writes the function power status bank
module fps_fw_model (
    input  wire logic        sys_clk_i,
    input  wire logic        pready_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pslverr_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [15:0]      paddr_o,
    output logic [31:0]      pwdata_o,
    output logic [3:0]       pstrb_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 16'h0;
        pwdata_o = 32'h0;
        pstrb_o = 4'hf;
    end

    // No slave latency is assumed: the request stands until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [15:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err);
        @(posedge sys_clk_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= addr;
        pwdata_o <= wdata;
        @(posedge sys_clk_i);
        penable_o <= 1'b1;
        @(posedge sys_clk_i iff pready_i === 1'b1);
        rdata = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // Idle data shows the inverse so a stale value is never mistaken for a live one
        pwdata_o <= ~wdata;
        // Return just past the edge so callers look at settled outputs
        #1;
    endtask : xfer
endmodule : fps_fw_model

/* tb/tb_function_power_status_upper.sv */
// Self-checking bench for the function power status register bank
module tb_function_power_status_upper import fps_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;

    logic           sys_clk_i;
    logic           reset_n_i;
    logic           psel;
    logic           penable;
    logic           pwrite;
    logic [15:0]    paddr;
    logic [31:0]    pwdata;
    logic [31:0]    prdata;
    logic [3:0]     pstrb;
    logic           pready;
    logic           pslverr;
    logic           strap;
    logic           mng_change;
    logic           irq;
    fps_func_stat_t f2;
    fps_func_stat_t f3;
    fps_func_stat_t f4;
    fps_nvm_word_t  nvm;
    int             fail_count;
    int             compares;
    logic           k;
    logic           s;
    logic           d;
    logic [31:0]    rv;
    logic           ev;

    fps_top fps_top_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pstrb_i(pstrb), .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .func2_i(f2), .func3_i(f3), .func4_i(f4), .nvm_word_i(nvm),
        .single_port_strap_i(strap), .mng_change_o(mng_change), .irq_o(irq));

    fps_fw_model fw_inst (.sys_clk_i(sys_clk_i), .pready_i(pready), .prdata_i(prdata),
        .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb));

    initial sys_clk_i = 1'b0;
    always #25 sys_clk_i = ~sys_clk_i;

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] exp_word();
        logic [31:0] w;
        w = 32'h0;
        w[26] = k;
        w[25:24] = f4.power_level;
        w[21] = f3.aux_pm_shadow;
        w[20] = s;
        w[19:18] = f3.power_level;
        w[15] = f2.aux_pm_shadow;
        w[14] = d;
        w[13:12] = f2.power_level;
        return w;
    endfunction : exp_word

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic [31:0] m);
        fw_inst.xfer(1'b0, a, 32'h0, rv, ev);
        chk(rv & m, exp & m);
        chk({31'h0, ev}, 32'h0);
    endtask : rd_chk

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        fw_inst.xfer(1'b1, a, v, rv, ev);
    endtask : wr

    task automatic set_f(input logic [2:0] a, input logic [2:0] b, input logic [2:0] c);
        @(posedge sys_clk_i);
        f2 <= a;
        f3 <= b;
        f4 <= c;
        tick(3);
    endtask : set_f

    task automatic nvm_send(input logic [7:0] a, input logic [15:0] v);
        @(posedge sys_clk_i);
        nvm <= '{1'b1, a, v};
        @(posedge sys_clk_i);
        nvm.valid <= 1'b0;
        tick(2);
    endtask : nvm_send

    // Strap is latched once it reads single port, so a change back to dual port needs a new reset
    task automatic do_reset(input logic sp);
        @(posedge sys_clk_i);
        strap <= sp;
        reset_n_i <= 1'b0;
        // Functions sit in their reset power state while the device is held in reset
        f2 <= '0;
        f3 <= '0;
        f4 <= '0;
        {k, s, d} = 3'h0;
        tick(10);
        @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        tick(5);
    endtask : do_reset

    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        end_sim();
    end

    initial begin
        reset_n_i = 1'b0;
        strap = 1'b0;
        f2 = '0;
        f3 = '0;
        f4 = '0;
        nvm = '0;
        fail_count = 0;
        compares = 0;
        void'($urandom(59791));
        do_reset(1'b0);
        rd_chk(FUNC_ACT_PWR_ADDR, 32'h0, 32'hffff_ffff);
        chk({31'h0, mng_change}, 32'h0);
        $display("reset values test done");
        for (int i = 0; i < 4; i++) begin
            set_f({1'b1, 2'(i)}, {1'b0, 2'(i)}, {1'b1, ~2'(i)});
            rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        end
        for (int i = 0; i < 24; i++) begin
            set_f(3'($urandom()), 3'($urandom()), 3'($urandom()));
            rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        end
        wr(FUNC_ACT_PWR_ADDR, 32'hffff_ffff);
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        $display("function fields test done");
        nvm_send(8'h49, 16'h0007);
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        nvm_send(8'h21, 16'h0006);
        {s, d} = 2'h3;
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        nvm_send(8'h21, 16'h0002);
        d = 1'b0;
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        $display("dual port load test done");
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        tick(12);
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        tick(12);
        set_f({f2.aux_pm_shadow, ~f2.power_level}, f3, f4);
        tick(6);
        chk({31'h0, mng_change}, 32'h1);
        rd_chk(FUNC_ACT_PWR_ADDR, 32'h8000_0000, 32'h8000_0000);
        chk({31'h0, mng_change}, 32'h0);
        set_f(f2, {f3.aux_pm_shadow, ~f3.power_level}, f4);
        chk({31'h0, mng_change}, 32'h0);
        tick(2);
        chk({31'h0, mng_change}, 32'h0);
        for (int i = 0; i < 12 && mng_change !== 1'b1; i++) tick(1);
        chk({31'h0, mng_change}, 32'h1);
        // A level change that lands on the clearing read is delayed to the end of the quiet time
        fork
            set_f(f2, f3, {f4.aux_pm_shadow, ~f4.power_level});
            rd_chk(FUNC_ACT_PWR_ADDR, 32'h8000_0000, 32'h8000_0000);
        join
        tick(7);
        chk({31'h0, mng_change}, 32'h0);
        tick(2);
        chk({31'h0, mng_change}, 32'h1);
        $display("change flag test done");
        wr(IRQ_ENABLE_ADDR, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h1);
        rd_chk(IRQ_STATUS_ADDR, 32'h1, 32'hffff_ffff);
        wr(IRQ_CLEAR_ADDR, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h0);
        rd_chk(IRQ_STATUS_ADDR, 32'h0, 32'hffff_ffff);
        rd_chk(IRQ_CLEAR_ADDR, 32'h0, 32'hffff_ffff);
        wr(IRQ_ENABLE_ADDR, 32'h0);
        set_f(f2, f3, {f4.aux_pm_shadow, ~f4.power_level});
        tick(2);
        rd_chk(IRQ_STATUS_ADDR, 32'h1, 32'hffff_ffff);
        chk({31'h0, irq}, 32'h0);
        rd_chk(IRQ_ENABLE_ADDR, 32'h0, 32'hffff_ffff);
        wr(IRQ_ENABLE_ADDR, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h1);
        wr(IRQ_CLEAR_ADDR, 32'h1);
        tick(1);
        chk({31'h0, irq}, 32'h0);
        fw_inst.xfer(1'b0, 16'h5b50, 32'h0, rv, ev);
        chk({31'h0, ev}, 32'h1);
        chk(rv, 32'h0);
        $display("interrupt and bus test done");
        do_reset(1'b1);
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'hffff_ffff);
        nvm_send(8'h21, 16'h0007);
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        nvm_send(8'h49, 16'h0007);
        {k, s, d} = 3'h7;
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        nvm_send(8'h49, 16'h0001);
        {s, d} = 2'h0;
        rd_chk(FUNC_ACT_PWR_ADDR, exp_word(), 32'h7fff_ffff);
        $display("single port load test done");
        end_sim();
    end
endmodule : tb_function_power_status_upper
